/* rtl/apm_pkg.sv */
// shared constants for the adc power management sequencer
package apm_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL_OFF   = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  // control field positions
  localparam int MODE_LO_BIT = 0;
  localparam int MODE_HI_BIT = 1;
  localparam int SW_CONV_BIT = 2;
  localparam int SW_CAL_BIT  = 3;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] MODE_NORM  = 2'h1;
  localparam logic [1:0] MODE_FULL  = 2'h2;
  localparam logic [1:0] MODE_PART  = 2'h3;
  // timing
  localparam int CLK_MHZ      = 125;
  localparam int WAKE_NS      = 5000;
  localparam int WAKE_CYC     = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int CAL_US_DEF   = 32000;
  localparam int CONV_NS      = 4600;
  localparam int CONV_CYC     = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W        = 24;
  typedef enum logic [3:0] {
    PS_RUN  = 4'b0001,
    PS_FULL = 4'b0010,
    PS_PART = 4'b0100,
    PS_WAKE = 4'b1000
  } apm_pwr_t;
endpackage

/* rtl/apm_if.sv */
// sync pin filter carrying a raw pin and its clean level
`timescale 1ns/100ps
interface apm_pin_if;
  logic raw;
  logic clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface

module apm_sync (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pin
  apm_pin_if.filt   pin
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic       cl_q;
  logic       cl_d;
  always_comb begin
    sh_d = {sh_q[1:0], pin.raw};
    cl_d = (sh_q[2] == sh_q[1]) ? sh_q[2] : cl_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q <= 3'h7;
      cl_q <= 1'b1;
    end else begin
      sh_q <= sh_d;
      cl_q <= cl_d;
    end
  end
  assign pin.clean = cl_q;
endmodule

/* rtl/apm_top.sv */
// power management sequencer: apb control, pin sync, power state machine
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/100ps
module apm_top #(
  parameter int CAL_CYC = apm_pkg::CAL_US_DEF * apm_pkg::CLK_MHZ
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins
  input  wire logic        sleep_n,
  input  wire logic        calibrate_n,
  input  wire logic        conversion_start_n,
  // power and analog controls
  output logic             core_power_on,
  output logic             ref_power_on,
  output logic             ready,
  output logic             busy,
  output logic             calibrating,
  output logic             track_mode
);
  // ==========================================================
  // pin synchronisers
  apm_pin_if sl_if ();
  apm_pin_if ca_if ();
  apm_pin_if cv_if ();
  assign sl_if.raw = sleep_n;
  assign ca_if.raw = calibrate_n;
  assign cv_if.raw = conversion_start_n;
  apm_sync u_sl (.pclk(pclk), .presetn(presetn), .pin(sl_if));
  apm_sync u_ca (.pclk(pclk), .presetn(presetn), .pin(ca_if));
  apm_sync u_cv (.pclk(pclk), .presetn(presetn), .pin(cv_if));
  logic sleep_s;
  logic cal_s;
  logic cv_s;
  assign sleep_s = sl_if.clean;
  assign cal_s   = ca_if.clean;
  assign cv_s    = cv_if.clean;

  // ==========================================================
  // apb register file
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  logic       sw_conv;
  logic       sw_cal;
  logic       wr_ctrl;
  logic       acc;
  logic       hit;
  assign acc     = psel && penable;
  assign hit     = (paddr == apm_pkg::CTRL_OFF) || (paddr == apm_pkg::STATUS_OFF);
  assign pready  = 1'b1;
  assign pslverr = acc && !hit;
  assign wr_ctrl = acc && pwrite && (paddr == apm_pkg::CTRL_OFF) && pstrb[0];
  assign sw_conv = wr_ctrl && pwdata[apm_pkg::SW_CONV_BIT];
  assign sw_cal  = wr_ctrl && pwdata[apm_pkg::SW_CAL_BIT];
  always_comb begin
    mode_d = mode_q;
    if (wr_ctrl) begin
      mode_d = {pwdata[apm_pkg::MODE_HI_BIT], pwdata[apm_pkg::MODE_LO_BIT]};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= apm_pkg::MODE_RESET;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ==========================================================
  // conversion start edges and power-on calibration
  logic cv_prev_q;
  logic cv_fall;
  logic cv_rise;
  logic por_q;
  logic por_d;
  logic cal_run_q;
  logic cal_run_d;
  logic por_cal_q;
  logic por_cal_d;
  localparam int CNT_W_L = 24;
  logic [CNT_W_L-1:0] cal_cnt_q;
  logic [CNT_W_L-1:0] cal_cnt_d;
  localparam logic [23:0] CAL_LAST = 24'(CAL_CYC - 1);
  assign cv_fall = cv_prev_q && !cv_s;
  assign cv_rise = !cv_prev_q && cv_s;
  always_comb begin
    por_d     = 1'b0;
    cal_run_d = cal_run_q;
    por_cal_d = por_cal_q;
    cal_cnt_d = cal_cnt_q;
    if (por_q) begin
      // strap caught after reset release, once the pin filter settled
      cal_run_d = !cal_s;
      por_cal_d = !cal_s;
      cal_cnt_d = '0;
    end else if (cal_run_q) begin
      if (cal_cnt_q == CAL_LAST) begin
        cal_run_d = 1'b0;
        por_cal_d = 1'b0;
      end else begin
        cal_cnt_d = cal_cnt_q + 24'h000001;
      end
    end else if (sw_cal) begin
      cal_run_d = 1'b1;
      cal_cnt_d = '0;
    end
  end
  // strap read well after the three-stage pin filter has settled
  logic [2:0] por_wait_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cv_prev_q  <= 1'b1;
      por_wait_q <= 3'h0;
      por_q      <= 1'b0;
      cal_run_q  <= 1'b0;
      por_cal_q  <= 1'b1;
      cal_cnt_q  <= '0;
    end else begin
      cv_prev_q  <= cv_s;
      por_wait_q <= (por_wait_q == 3'h7) ? por_wait_q : por_wait_q + 3'h1;
      por_q      <= (por_wait_q == 3'h5);
      cal_run_q  <= cal_run_d;
      por_cal_q  <= por_cal_d;
      cal_cnt_q  <= cal_cnt_d;
    end
  end

  // ==========================================================
  // conversion timer
  logic        conv_q;
  logic        conv_d;
  logic [10:0] conv_cnt_q;
  logic [10:0] conv_cnt_d;
  logic        conv_done;
  logic        start;
  localparam logic [10:0] CONV_LAST = 11'(apm_pkg::CONV_CYC - 1);
  assign conv_done = conv_q && (conv_cnt_q == CONV_LAST);
  always_comb begin
    conv_d     = conv_q;
    conv_cnt_d = conv_cnt_q;
    if (conv_done) begin
      conv_d = 1'b0;
    end else if (conv_q) begin
      conv_cnt_d = conv_cnt_q + 11'h001;
    end else if (start) begin
      conv_d     = 1'b1;
      conv_cnt_d = '0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_q     <= 1'b0;
      conv_cnt_q <= '0;
    end else begin
      conv_q     <= conv_d;
      conv_cnt_q <= conv_cnt_d;
    end
  end

  // ==========================================================
  // power state machine
  apm_pkg::apm_pwr_t st_q;
  apm_pkg::apm_pwr_t st_d;
  logic [10:0] wk_cnt_q;
  logic [10:0] wk_cnt_d;
  logic        want_full;
  logic        want_part;
  logic        idle;
  localparam logic [10:0] WAKE_LAST = 11'(apm_pkg::WAKE_CYC - 1);
  assign idle = !conv_q && !cal_run_q;
  // sleep low with mode 00 is also power-down between conversions
  assign want_full = (mode_q == apm_pkg::MODE_FULL) ||
                     ((mode_q == apm_pkg::MODE_SLEEP) && !sleep_s && idle && !por_cal_q && cv_s);
  assign want_part = (mode_q == apm_pkg::MODE_PART) && !conv_q;
  // a conversion only starts from a powered core
  assign start = (st_q == apm_pkg::PS_RUN) && (cv_rise || sw_conv);
  always_comb begin
    st_d     = st_q;
    wk_cnt_d = wk_cnt_q;
    case (st_q)
      apm_pkg::PS_RUN: begin
        if (conv_done && want_full) begin
          st_d = apm_pkg::PS_FULL;
        end else if (!conv_q && !cal_run_q && want_full && !start) begin
          st_d = apm_pkg::PS_FULL;
        end else if (want_part && !cal_run_q && !sw_cal) begin
          st_d = apm_pkg::PS_PART;
        end
      end
      apm_pkg::PS_FULL, apm_pkg::PS_PART: begin
        if (cv_fall || (!want_full && !want_part) || sw_cal) begin
          st_d     = apm_pkg::PS_WAKE;
          wk_cnt_d = '0;
        end else if (want_full) begin
          st_d = apm_pkg::PS_FULL;
        end else begin
          st_d = apm_pkg::PS_PART;
        end
      end
      apm_pkg::PS_WAKE: begin
        if (wk_cnt_q == WAKE_LAST) begin
          st_d = apm_pkg::PS_RUN;
        end else begin
          wk_cnt_d = wk_cnt_q + 11'h001;
        end
      end
      default: begin
        st_d = apm_pkg::PS_RUN;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= apm_pkg::PS_RUN;
      wk_cnt_q <= '0;
    end else begin
      st_q     <= st_d;
      wk_cnt_q <= wk_cnt_d;
    end
  end

  // ==========================================================
  // outputs
  logic [31:0] rd_d;
  logic [31:0] rd_q;
  always_comb begin
    rd_d = 32'h0;
    if (paddr == apm_pkg::CTRL_OFF) begin
      rd_d = {30'h0, mode_q};
    end else if (paddr == apm_pkg::STATUS_OFF) begin
      rd_d = {24'h0, st_q, calibrating, conv_q, ready, core_power_on};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 32'h0;
    end else begin
      rd_q <= (psel && !penable && !pwrite) ? rd_d : rd_q;
    end
  end
  assign prdata        = rd_q;
  assign core_power_on = (st_q != apm_pkg::PS_FULL) && (st_q != apm_pkg::PS_PART);
  assign ref_power_on  = (st_q != apm_pkg::PS_FULL);
  assign ready         = (st_q == apm_pkg::PS_RUN);
  assign busy          = conv_q;
  assign calibrating   = cal_run_q;
  assign track_mode    = !conv_q;

  // ==========================================================
  // checks
  a_wake_time: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == apm_pkg::PS_FULL) && (st_d == apm_pkg::PS_WAKE) |=> !ready [*8] ##[1:700] ready)
    else $error("wake did not finish in time");
  a_norm_stays: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == apm_pkg::MODE_NORM) && ready && !sw_cal |=> core_power_on)
    else $error("normal mode powered down");
  a_sleep_high: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == apm_pkg::MODE_SLEEP) && sleep_s && ready |=> core_power_on)
    else $error("sleep high powered down");
  a_cal_nodown: assert property (@(posedge pclk) disable iff (!presetn)
    por_cal_q && (mode_q == apm_pkg::MODE_SLEEP) |-> core_power_on)
    else $error("power-down during power-on calibration");
  a_busy_down: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(busy) && (mode_q == apm_pkg::MODE_FULL) |-> ##1 !core_power_on && !ref_power_on)
    else $error("no power-down after conversion");
  a_part_ref: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == apm_pkg::PS_PART) |-> ref_power_on && !core_power_on)
    else $error("partial down lost reference");
  a_track_busy: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(busy) |-> track_mode && $past(!track_mode))
    else $error("track mode not restored");
  a_conv_start: assert property (@(posedge pclk) disable iff (!presetn)
    ready && cv_rise && !conv_q |=> busy [*8])
    else $error("conversion did not start");
  a_cal_strap: assert property (@(posedge pclk) disable iff (!presetn)
    por_q && cal_s |=> !calibrating)
    else $error("power-on calibration not skipped");
  a_part_aftercal: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(cal_run_q) && !wr_ctrl && ($past(st_q) == apm_pkg::PS_RUN) && !$past(want_part) |-> st_q != apm_pkg::PS_PART)
    else $error("partial down entered after calibration");
endmodule

/* testbench/apm_host_model.sv */
// host model: apb master and pin driver for the sequencer
`timescale 1ns/100ps
module apm_host_model (
  // clock
  input  wire logic        pclk,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // pins
  output logic             sleep_n,
  output logic             calibrate_n,
  output logic             conversion_start_n
);
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    sleep_n = 1'b0;
    calibrate_n = 1'b0;
    conversion_start_n = 1'b1;
  end
  // caller enters just after an edge; waits out any pready wait states
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* testbench/adc_power_management_bench.sv */
// self-checking bench for the power management sequencer
`timescale 1ns/100ps
module adc_power_management_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic        sleep_n, calibrate_n, conversion_start_n, err;
  logic        core_power_on, ref_power_on, ready, busy, calibrating, track_mode;
  logic [5:0]  st;
  int          miscompares = 0;
  int          total_checks = 0;
  localparam int CAL = 50;
  localparam logic [11:0] CT = apm_pkg::CTRL_OFF;
  assign st = {track_mode, calibrating, busy, ready, ref_power_on, core_power_on};

  apm_top #(.CAL_CYC(CAL)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .sleep_n, .calibrate_n,
    .conversion_start_n, .core_power_on, .ref_power_on, .ready, .busy,
    .calibrating, .track_mode);
  apm_host_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .sleep_n, .calibrate_n, .conversion_start_n);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ==========
  // helpers
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wrap_up;
    if (miscompares == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    host.xfer(1'b1, a, d, q, err);
  endtask
  task rd(input logic [11:0] a);
    @(posedge pclk);
    host.xfer(1'b0, a, 32'h0, q, err);
  endtask
  // bounded wait, sampled off the edge; a miss shows in the next check
  task wt(input int b, input logic v, input int lim);
    #1;
    for (int i = 0; i < lim && st[b] !== v; i++) #8;
  endtask
  // ==========
  // scenarios
  task t_powerup;
    wt(4, 1'b1, 20);
    chk("calibrating", calibrating, 1'b1);
    #(8 * CAL / 2);
    chk("core_on_in_cal", core_power_on, 1'b1);
    wt(4, 1'b0, CAL + 20);
    wt(0, 1'b0, 20);
    chk("ref_full_down", ref_power_on, 1'b0);
    rd(CT);
    chk("mode_reset", q[1:0], 2'h0);
    rd(apm_pkg::STATUS_OFF);
    chk("status_full", q[7:0], 8'h20);
    rd(12'h010);
    chk("unmapped_err", err, 1'b1);
  endtask
  task t_sleep_high;
    host.sleep_n <= 1'b1;
    wt(2, 1'b1, 700);
    chk("ready_awake", ready, 1'b1);
    #400;
    chk("core_held", core_power_on, 1'b1);
  endtask
  task t_modes;
    host.sleep_n <= 1'b0;
    wr(CT, 32'h3);
    wt(0, 1'b0, 20);
    chk("part_ref", ref_power_on, 1'b1);
    wr(CT, 32'h2);
    wt(1, 1'b0, 20);
    chk("full_core", core_power_on, 1'b0);
    chk("full_ref", ref_power_on, 1'b0);
    wr(CT, 32'h1);
    wt(2, 1'b1, 700);
    rd(apm_pkg::STATUS_OFF);
    chk("status_run", q[7:0], 8'h13);
  endtask
  task t_sw_cal;
    wr(CT, 32'h9);
    wt(4, 1'b1, 20);
    wr(CT, 32'h3);
    wt(0, 1'b0, 20);
    chk("cal_part_ref", ref_power_on, 1'b1);
    wr(CT, 32'h1);
    wt(4, 1'b0, CAL + 20);
    wt(2, 1'b1, 700);
    #80;
    chk("no_auto_part", core_power_on, 1'b1);
  endtask
  task t_between;
    wr(CT, 32'h0);
    wt(0, 1'b0, 20);
    host.conversion_start_n <= 1'b0;
    wt(2, 1'b1, 700);
    chk("wake_ready", ready, 1'b1);
    #400;
    host.conversion_start_n <= 1'b1;
    wt(3, 1'b1, 20);
    chk("hold_mode", track_mode, 1'b0);
    wt(3, 1'b0, 700);
    wt(0, 1'b0, 5);
    chk("auto_down", core_power_on, 1'b0);
    chk("tracking", track_mode, 1'b1);
  endtask
  task t_no_autocal;
    @(posedge pclk);
    presetn <= 1'b0;
    host.calibrate_n <= 1'b1;
    host.sleep_n <= 1'b1;
    #24;
    presetn <= 1'b1;
    #160;
    chk("skip_cal", calibrating, 1'b0);
    #400;
    wr(CT, 32'h9);
    wt(4, 1'b1, 20);
    chk("sw_cal_start", calibrating, 1'b1);
  endtask
  // ==========
  // main sequence and watchdog
  initial begin
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_powerup();
    t_sleep_high();
    t_modes();
    t_sw_cal();
    t_between();
    t_no_autocal();
    wrap_up();
  end
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
endmodule
